// file: design/snc_pkg.sv
// snc_pkg: register map, field layout and reset values of the node configuration bank
package snc_pkg;
   // register indices (configuration address space, word addressed)
   localparam logic [7:0] REG_IDENTITY    = 8'h00;
   localparam logic [7:0] REG_TOPOLOGY    = 8'h01;
   localparam logic [7:0] REG_LOCK_HDR    = 8'h04;
   localparam logic [7:0] REG_NODE_ADDR   = 8'h05;
   localparam logic [7:0] REG_PLL         = 8'h06;
   localparam logic [7:0] REG_SW_CLK_DIV  = 8'h07;
   localparam logic [7:0] REG_REF_CLK_DIV = 8'h08;
   localparam logic [7:0] REG_TP_DEV_CODE = 8'h09;
   localparam logic [7:0] REG_TP_USER     = 8'h0a;
   localparam logic [7:0] REG_DIR_LOW     = 8'h0c;
   localparam logic [7:0] REG_DIR_HIGH    = 8'h0d;

   // switch configuration fields
   localparam int LOCK_ALL_BIT   = 31;
   localparam int LOCK_PLL_BIT   = 8;
   localparam int HDR_MODE_BIT   = 0;

   // pll settings fields
   localparam int PLL_NO_RST_BIT   = 31;
   localparam int PLL_NO_WAIT_BIT  = 30;
   localparam int PLL_BYPASS_BIT   = 29;
   localparam int PLL_TP_BOOT_BIT  = 28;
   localparam logic [31:0] PLL_WR_MASK = 32'hf39fff7f;

   // writable masks and reset values
   localparam logic [31:0] LOCK_HDR_MASK = 32'h80000101;
   localparam logic [31:0] LOW16_MASK    = 32'h0000ffff;
   localparam logic [15:0] REF_DIV_RST   = 16'h0003;
   localparam logic [31:0] PLL_RST       = 32'h00000000;

   localparam int DIR_W  = 4;
   localparam int NODE_W = 16;
endpackage

// file: design/snc_route_sel.sv
// snc_route_sel: picks the direction field from the most significant mismatching address bit
`timescale 1ns/1ps
`default_nettype none
module snc_route_sel (
   // addresses
   input  wire logic [15:0]  i_dest_addr,
   input  wire logic [15:0]  i_own_addr,
   // direction tables
   input  wire logic [31:0]  i_dir_low,
   input  wire logic [31:0]  i_dir_high,
   // result
   output logic              o_local,
   output logic [3:0]        o_dir
);
   import snc_pkg::*;
   logic [15:0] diff;
   logic [63:0] table_all;
   assign diff      = i_dest_addr ^ i_own_addr;
   assign table_all = {i_dir_high, i_dir_low};
   assign o_local   = (diff == 16'h0000);             // R23

   always_comb begin
      o_dir = 4'h0;
      for (int n = 0; n < NODE_W; n++) begin
         if (diff[n]) begin
            o_dir = table_all[n*DIR_W +: DIR_W];       // R21
         end
      end
   end
endmodule
`default_nettype wire

// file: design/snc_config_bank.sv
// snc_config_bank: node configuration register bank with route lookup
//
// Operation
// (R1) registers reached only by configuration reads and writes addressed to this node
// (R2) identity word: boot pins at power-on 23:16, revision 15:8, version 7:0
// (R3) topology word: link count 23:16, router processors 15:8, device processors 7:0
// (R4) lock bit 31 set blocks writes to all router control registers
// (R5) lock bit 8 set blocks writes to the pll settings register
// (R6) header bit 0: zero two-byte headers, one one-byte headers
// (R7) node address is writable 16 bits, reset zero, upper bits reserved
// (R8) accepted pll settings write resets the tile unless suppressed
// (R9) pll write with bit 31 set applies settings without chip reset
// (R10) pll write with bit 30 set skips waiting for pll relock
// (R11) pll bit 29 bypasses the pll with the input clock
// (R12) pll bit 28 forces boot through the test access port
// (R13) pll bits 25:23 hold output divider, values 0 to 7
// (R14) pll bits 20:8 hold feedback multiplication ratio
// (R15) pll bits 6:0 hold input divider value
// (R16) switch clock divider 16 bits writable, resets to zero
// (R17) reference clock divider 16 bits writable, resets to three
// (R18) user code word: otp code 31:18, metal id 17:0, read-only
// (R19) low direction table: dimension n at bits 4n+3:4n, reset zero
// (R20) high direction table: dimensions 8 to 15, reset zero
// (R21) route by field of the most significant differing address bit
// (R22) each link has a 4-bit direction; matching direction may forward there
// (R23) a fully matching address is delivered locally
// (R24) reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module snc_config_bank #(
   parameter logic [7:0]  REVISION    = 8'h01,   // arbitrary
   parameter logic [7:0]  VERSION     = 8'h01,   // arbitrary
   parameter logic [7:0]  NUM_LINKS   = 8'h08,
   parameter logic [7:0]  NUM_PROC_SW = 8'h02,
   parameter logic [7:0]  NUM_PROC_DV = 8'h02,
   parameter logic [31:0] TP_DEV_CODE = 32'h00000001, // arbitrary
   parameter logic [17:0] METAL_ID    = 18'h00001,    // arbitrary
   parameter int          LINKS       = 8
) (
   // clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst_b,
   // configuration access
   input  wire logic                     i_cfg_wr,
   input  wire logic                     i_cfg_rd,
   input  wire logic [7:0]               i_cfg_addr,
   input  wire logic [31:0]              i_cfg_wdata,
   output logic                          o_cfg_rvalid,
   output logic [31:0]                   o_cfg_rdata,
   // straps and otp
   input  wire logic [7:0]               i_boot_select_pins,
   input  wire logic [13:0]              i_otp_user_code,
   // routing
   input  wire logic                     i_pkt_valid,
   input  wire logic [15:0]              i_pkt_dest,
   input  wire logic [LINKS*4-1:0]       i_link_dir,
   output logic                          o_route_valid,
   output logic                          o_route_local,
   output logic [3:0]                    o_route_dir,
   output logic [LINKS-1:0]              o_link_match,
   // configuration outputs
   output logic                          o_one_byte_hdr,
   output logic [15:0]                   o_node_addr,
   output logic [31:0]                   o_pll_settings,
   output logic                          o_pll_bypass,
   output logic                          o_tp_boot,
   output logic                          o_tile_reset,
   output logic                          o_pll_wait_lock,
   output logic [15:0]                   o_sw_clk_div,
   output logic [15:0]                   o_ref_clk_div
);
   import snc_pkg::*;

   // ----------------------------------------
   // pin capture
   // ----------------------------------------
   logic [7:0]  boot_meta;
   logic [7:0]  boot_sync;
   logic [7:0]  boot_latched;
   logic        boot_taken;
   logic [13:0] otp_meta;
   logic [13:0] otp_sync;
   localparam int SYNC_STAGES = 2;
   logic [SYNC_STAGES-1:0] sync_fill;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         boot_meta <= 8'h00;
         boot_sync <= 8'h00;
         otp_meta  <= 14'h0000;
         otp_sync  <= 14'h0000;
      end else begin
         boot_meta <= i_boot_select_pins;
         boot_sync <= boot_meta;
         otp_meta  <= i_otp_user_code;
         otp_sync  <= otp_meta;
      end
   end

   // marks when both synchroniser stages hold pin samples rather than reset zeros
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_fill <= '0;
      end else begin
         sync_fill <= {sync_fill[SYNC_STAGES-2:0], 1'b1};
      end
   end

   // straps held from the first sample that has passed both stages
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         boot_latched <= 8'h00;
         boot_taken   <= 1'b0;
      end else if (sync_fill[SYNC_STAGES-1] && !boot_taken) begin
         boot_latched <= boot_sync;                    // R2
         boot_taken   <= 1'b1;
      end
   end

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   logic [31:0] lock_hdr;
   logic [15:0] node_addr;
   logic [31:0] pll;
   logic [15:0] sw_div;
   logic [15:0] ref_div;
   logic [31:0] dir_low;
   logic [31:0] dir_high;
   logic        wr_open;
   logic        pll_wr_ok;

   assign wr_open   = i_cfg_wr && !lock_hdr[LOCK_ALL_BIT];                // R1 R4
   assign pll_wr_ok = wr_open && (i_cfg_addr == REG_PLL)
                      && !lock_hdr[LOCK_PLL_BIT];                          // R5

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lock_hdr <= 32'h00000000;
      end else if (wr_open && i_cfg_addr == REG_LOCK_HDR) begin
         lock_hdr <= i_cfg_wdata & LOCK_HDR_MASK;      // R4 R5 R6 R24
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         node_addr <= 16'h0000;
      end else if (wr_open && i_cfg_addr == REG_NODE_ADDR) begin
         node_addr <= i_cfg_wdata[15:0];               // R7
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pll <= PLL_RST;
      end else if (pll_wr_ok) begin
         pll <= i_cfg_wdata & PLL_WR_MASK;             // R13 R14 R15 R24
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sw_div  <= 16'h0000;
         ref_div <= REF_DIV_RST;
      end else if (wr_open) begin
         if (i_cfg_addr == REG_SW_CLK_DIV) begin
            sw_div <= i_cfg_wdata[15:0];               // R16
         end
         if (i_cfg_addr == REG_REF_CLK_DIV) begin
            ref_div <= i_cfg_wdata[15:0];              // R17
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dir_low  <= 32'h00000000;
         dir_high <= 32'h00000000;
      end else if (wr_open) begin
         if (i_cfg_addr == REG_DIR_LOW) begin
            dir_low <= i_cfg_wdata;                    // R19
         end
         if (i_cfg_addr == REG_DIR_HIGH) begin
            dir_high <= i_cfg_wdata;                   // R20
         end
      end
   end

   // ----------------------------------------
   // pll side effects
   // ----------------------------------------
   // one-cycle pulses; the clock generator owns relock timing
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tile_reset    <= 1'b0;
         o_pll_wait_lock <= 1'b0;
      end else begin
         o_tile_reset    <= pll_wr_ok && !i_cfg_wdata[PLL_NO_RST_BIT];    // R8 R9
         o_pll_wait_lock <= pll_wr_ok && !i_cfg_wdata[PLL_NO_WAIT_BIT];   // R10
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   logic [31:0] next_rdata;

   always_comb begin
      case (i_cfg_addr)
         REG_IDENTITY:    next_rdata = {8'h00, boot_latched, REVISION, VERSION};      // R2
         REG_TOPOLOGY:    next_rdata = {8'h00, NUM_LINKS, NUM_PROC_SW, NUM_PROC_DV};  // R3
         REG_LOCK_HDR:    next_rdata = lock_hdr;
         REG_NODE_ADDR:   next_rdata = {16'h0000, node_addr};                         // R24
         REG_PLL:         next_rdata = pll;
         REG_SW_CLK_DIV:  next_rdata = {16'h0000, sw_div};
         REG_REF_CLK_DIV: next_rdata = {16'h0000, ref_div};
         REG_TP_DEV_CODE: next_rdata = TP_DEV_CODE;
         REG_TP_USER:     next_rdata = {otp_sync, METAL_ID};                          // R18
         REG_DIR_LOW:     next_rdata = dir_low;
         REG_DIR_HIGH:    next_rdata = dir_high;
         default:         next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cfg_rvalid <= 1'b0;
         o_cfg_rdata  <= 32'h00000000;
      end else begin
         o_cfg_rvalid <= i_cfg_rd;                     // R1
         if (i_cfg_rd) begin
            o_cfg_rdata <= next_rdata;
         end
      end
   end

   // ----------------------------------------
   // configuration outputs
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_one_byte_hdr <= 1'b0;
         o_node_addr    <= 16'h0000;
         o_pll_settings <= PLL_RST;
         o_pll_bypass   <= 1'b0;
         o_tp_boot      <= 1'b0;
         o_sw_clk_div   <= 16'h0000;
         o_ref_clk_div  <= REF_DIV_RST;
      end else begin
         o_one_byte_hdr <= lock_hdr[HDR_MODE_BIT];     // R6
         o_node_addr    <= node_addr;
         o_pll_settings <= pll;
         o_pll_bypass   <= pll[PLL_BYPASS_BIT];        // R11
         o_tp_boot      <= pll[PLL_TP_BOOT_BIT];       // R12
         o_sw_clk_div   <= sw_div;
         o_ref_clk_div  <= ref_div;
      end
   end

   // ----------------------------------------
   // routing
   // ----------------------------------------
   logic       sel_local;
   logic [3:0] sel_dir;

   snc_route_sel u_route_sel (
      .i_dest_addr (i_pkt_dest),
      .i_own_addr  (node_addr),
      .i_dir_low   (dir_low),
      .i_dir_high  (dir_high),
      .o_local     (sel_local),
      .o_dir       (sel_dir)
   );

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_route_valid <= 1'b0;
         o_route_local <= 1'b0;
         o_route_dir   <= 4'h0;
      end else begin
         o_route_valid <= i_pkt_valid;
         o_route_local <= sel_local;                   // R23
         o_route_dir   <= sel_dir;                     // R21
      end
   end

   genvar g;
   generate
      for (g = 0; g < LINKS; g++) begin : g_link
         always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               o_link_match[g] <= 1'b0;
            end else begin
               o_link_match[g] <= i_pkt_valid && !sel_local
                                  && (i_link_dir[g*DIR_W +: DIR_W] == sel_dir);   // R22
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_lock_blocks_all: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R4
      lock_hdr[LOCK_ALL_BIT] |=> $stable(node_addr) && $stable(dir_low))
      else $error("write passed while router registers locked");
   chk_pll_lock_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R5
      (lock_hdr[LOCK_PLL_BIT] || lock_hdr[LOCK_ALL_BIT]) |=> $stable(pll))
      else $error("pll settings changed while locked");
   chk_tile_reset_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R8
      o_tile_reset |-> $past(pll_wr_ok) && !$past(i_cfg_wdata[PLL_NO_RST_BIT]))
      else $error("tile reset without accepted pll write");
   chk_no_reset_bit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R9
      (pll_wr_ok && i_cfg_wdata[PLL_NO_RST_BIT]) |=> !o_tile_reset)
      else $error("tile reset despite suppress bit");
   chk_wait_lock: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R10
      (pll_wr_ok && !i_cfg_wdata[PLL_NO_WAIT_BIT]) |=> o_pll_wait_lock)
      else $error("relock wait missing");
   chk_hdr_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R6
      ##1 o_one_byte_hdr == $past(lock_hdr[HDR_MODE_BIT]))
      else $error("header mode output wrong");
   chk_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R24
      (i_cfg_rd && i_cfg_addr == REG_NODE_ADDR) |=> o_cfg_rdata[31:16] == 16'h0000)
      else $error("reserved bits read nonzero");
   chk_local_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R23
      (i_pkt_dest == node_addr) |=> o_route_local && o_link_match == '0)
      else $error("own address not delivered locally");
   chk_route_top_bit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R21 R20
      ((i_pkt_dest ^ node_addr) >> (NODE_W-1) == 16'h0001)
      |=> o_route_dir == $past(dir_high[$bits(dir_high)-DIR_W +: DIR_W]))
      else $error("wrong direction for top mismatch");
   chk_read_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R17
      (i_cfg_rd && i_cfg_addr == REG_REF_CLK_DIV) |=> o_cfg_rdata == {16'h0000, $past(ref_div)})
      else $error("reference divider read wrong");
   chk_boot_held: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R2
      boot_taken |=> $stable(boot_latched))
      else $error("boot strap capture changed after it was taken");
   chk_read_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R1
      i_cfg_rd |=> o_cfg_rvalid)
      else $error("read not answered in the next cycle");
   chk_link_needs_pkt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R22
      !i_pkt_valid |=> o_link_match == '0)
      else $error("link match raised without a packet");
endmodule
`default_nettype wire

// file: verif/snc_cfg_agent.sv
// snc_cfg_agent: configuration access agent driving the bank's register port
`timescale 1ns/1ps
`default_nettype none
module snc_cfg_agent (
   // clock
   input  wire logic        i_ref_clk,
   // configuration access
   output logic             o_cfg_wr,
   output logic             o_cfg_rd,
   output logic [7:0]       o_cfg_addr,
   output logic [31:0]      o_cfg_wdata,
   input  wire logic        i_cfg_rvalid,
   input  wire logic [31:0] i_cfg_rdata
);
   initial begin
      o_cfg_wr    = 1'b0;
      o_cfg_rd    = 1'b0;
      o_cfg_addr  = 8'h00;
      o_cfg_wdata = 32'h00000000;
   end
   task automatic write(input logic [7:0] addr, input logic [31:0] data);
      @(posedge i_ref_clk);
      o_cfg_wr    <= 1'b1;
      o_cfg_addr  <= addr;
      o_cfg_wdata <= data;
      @(posedge i_ref_clk);
      o_cfg_wr    <= 1'b0;
      // idle lines scrambled so a stale value is never relied on
      o_cfg_addr  <= ~addr;
      o_cfg_wdata <= ~data;
   endtask
   task automatic read(input logic [7:0] addr, output logic [31:0] data, output logic ok);
      int n;
      ok = 1'b0;
      data = 32'h00000000;
      @(posedge i_ref_clk);
      o_cfg_rd   <= 1'b1;
      o_cfg_addr <= addr;
      @(posedge i_ref_clk);
      o_cfg_rd   <= 1'b0;
      o_cfg_addr <= ~addr;
      for (n = 0; n < 4 && !ok; n++) begin
         @(negedge i_ref_clk);
         if (i_cfg_rvalid === 1'b1) begin
            ok = 1'b1;
            data = i_cfg_rdata;
         end
      end
   endtask
endmodule
`default_nettype wire

// file: verif/test_switch_node_config_bank.sv
// test_switch_node_config_bank: register and route checks of the node configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_switch_node_config_bank;
   import snc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        wr, rd, rvalid, ok, pkt_valid, route_valid, route_local, one_byte;
   logic        bypass, tp_boot, tile_reset, wait_lock;
   logic [7:0]  addr, link_match;
   logic [31:0] wdata, rdata, pll, v;
   logic [15:0] pkt_dest, node_addr, sw_div, ref_div;
   logic [3:0]  route_dir;
   logic [7:0]  zero_regs [5] = '{8'h05, 8'h06, 8'h07, 8'h0c, 8'h0d};
   int          failures = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          b;

   always #50 clk = ~clk;
   initial begin
      pkt_valid = 1'b0;
      pkt_dest  = 16'h0000;
   end

   snc_cfg_agent agent (.i_ref_clk(clk), .o_cfg_wr(wr), .o_cfg_rd(rd), .o_cfg_addr(addr),
      .o_cfg_wdata(wdata), .i_cfg_rvalid(rvalid), .i_cfg_rdata(rdata));

   // identity values arbitrary, chosen apart from the design defaults
   snc_config_bank #(.REVISION(8'h12), .VERSION(8'h34), .NUM_PROC_DV(8'h03),
      .TP_DEV_CODE(32'h13572468), .METAL_ID(18'h2d2d3)) uut (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_cfg_wr(wr), .i_cfg_rd(rd),
      .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rvalid(rvalid), .o_cfg_rdata(rdata),
      .i_boot_select_pins(8'ha5), .i_otp_user_code(14'h1abc), .i_pkt_valid(pkt_valid),
      .i_pkt_dest(pkt_dest), .i_link_dir(32'h76543210), .o_route_valid(route_valid),
      .o_route_local(route_local), .o_route_dir(route_dir), .o_link_match(link_match),
      .o_one_byte_hdr(one_byte), .o_node_addr(node_addr), .o_pll_settings(pll),
      .o_pll_bypass(bypass), .o_tp_boot(tp_boot), .o_tile_reset(tile_reset),
      .o_pll_wait_lock(wait_lock), .o_sw_clk_div(sw_div), .o_ref_clk_div(ref_div));

   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      agent.read(a, v, ok);
      chk("read valid", 32'h1, {31'h0, ok});
      chk($sformatf("register %h", a), exp, v);
   endtask
   // pulses may land one or two cycles after the write, so count over three
   task automatic pll_wr(input logic [31:0] d, input int n_rst, input int n_wait);
      int tr;
      int wl;
      tr = 0;
      wl = 0;
      agent.write(REG_PLL, d);
      repeat (3) begin
         @(negedge clk);
         tr += int'(tile_reset === 1'b1);
         wl += int'(wait_lock === 1'b1);
      end
      chk("tile reset pulses", 32'(n_rst), 32'(tr));
      chk("relock wait pulses", 32'(n_wait), 32'(wl));
   endtask
   task automatic route(input logic [15:0] d, input logic lcl, input logic [3:0] dir,
                        input logic [7:0] m);
      @(posedge clk);
      pkt_valid <= 1'b1;
      pkt_dest  <= d;
      @(posedge clk);
      pkt_valid <= 1'b0;
      pkt_dest  <= ~d;
      @(negedge clk);
      chk("route valid", 32'h1, {31'h0, route_valid});
      chk("route local", {31'h0, lcl}, {31'h0, route_local});
      chk("route dir", {28'h0, dir}, {28'h0, route_dir});
      chk("link match", {24'h0, m}, {24'h0, link_match});
   endtask

   // hang guard, the sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      chk("ref div in reset", 32'h3, {16'h0, ref_div});
      rst_b <= 1'b1;
      rd_chk(REG_REF_CLK_DIV, 32'h3);
      rd_chk(REG_LOCK_HDR, 32'h0);
      foreach (zero_regs[i]) rd_chk(zero_regs[i], 32'h0);
      rd_chk(REG_IDENTITY, 32'h00a51234);
      rd_chk(REG_TOPOLOGY, 32'h00080203);
      rd_chk(REG_TP_DEV_CODE, 32'h13572468);
      agent.write(REG_TP_USER, 32'h0);
      rd_chk(REG_TP_USER, {14'h1abc, 18'h2d2d3});
      rd_chk(8'h0b, 32'h0);
      agent.write(REG_NODE_ADDR, 32'hffffffff);
      agent.write(REG_SW_CLK_DIV, 32'hffffffff);
      agent.write(REG_REF_CLK_DIV, 32'hffffffff);
      rd_chk(REG_NODE_ADDR, 32'h0000ffff);
      rd_chk(REG_SW_CLK_DIV, 32'h0000ffff);
      rd_chk(REG_REF_CLK_DIV, 32'h0000ffff);
      chk("sw div out", 32'hffff, {16'h0, sw_div});
      chk("ref div out", 32'hffff, {16'h0, ref_div});
      agent.write(REG_DIR_LOW, 32'h76543210);
      agent.write(REG_DIR_HIGH, 32'hfedcba98);
      rd_chk(REG_DIR_LOW, 32'h76543210);
      rd_chk(REG_DIR_HIGH, 32'hfedcba98);
      agent.write(REG_NODE_ADDR, 32'h0000a5a5);
      repeat (2) @(negedge clk);
      chk("node addr out", 32'ha5a5, {16'h0, node_addr});
      route(16'ha5a5, 1'b1, 4'h0, 8'h00);
      // lower bits also differ so only the top mismatch may choose
      for (b = 0; b < 16; b++) begin
         route(16'ha5a5 ^ ((16'h1 << b) | ((16'h1 << b) - 16'h1)), 1'b0, b[3:0],
               (b < 8) ? (8'h1 << b) : 8'h00);
      end
      pll_wr(32'h3fffffff, 1, 1);
      chk("pll out", 32'h3fffffff & PLL_WR_MASK, pll);
      chk("bypass", 32'h1, {31'h0, bypass});
      chk("test boot", 32'h1, {31'h0, tp_boot});
      rd_chk(REG_PLL, 32'h339fff7f);
      pll_wr(32'hc0000000, 0, 0);
      chk("bypass off", 32'h0, {31'h0, bypass});
      agent.write(REG_LOCK_HDR, 32'h00000101);
      repeat (2) @(negedge clk);
      chk("one byte hdr", 32'h1, {31'h0, one_byte});
      pll_wr(32'h00000000, 0, 0);
      rd_chk(REG_PLL, 32'hc0000000);
      agent.write(REG_NODE_ADDR, 32'h00001234);
      rd_chk(REG_NODE_ADDR, 32'h00001234);
      agent.write(REG_LOCK_HDR, 32'hffffffff);
      rd_chk(REG_LOCK_HDR, 32'h80000101);
      agent.write(REG_NODE_ADDR, 32'h00005678);
      agent.write(REG_DIR_LOW, 32'h0);
      rd_chk(REG_NODE_ADDR, 32'h00001234);
      rd_chk(REG_DIR_LOW, 32'h76543210);
      // only a reset clears the lock; the straps must be taken afresh after it
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(REG_LOCK_HDR, 32'h0);
      rd_chk(REG_NODE_ADDR, 32'h0);
      rd_chk(REG_IDENTITY, 32'h00a51234);
      rd_chk(REG_REF_CLK_DIV, 32'h3);
      agent.write(REG_NODE_ADDR, 32'h00000042);
      rd_chk(REG_NODE_ADDR, 32'h00000042);
      final_report();
   end
endmodule
`default_nettype wire
